// [core/pesc_regs.sv]
// event, status, mask, output pin and converter control register bank
// ----------------------------------------------------------------------
// Notes on behaviour
// - overtemperature always sets event bit 7
// - supply lockout sets bit 6 unless masked
// - overcurrent sets bit 4 when enabled, unmasked
// - overvoltage sets bit 3 when enabled, unmasked
// - undervoltage sets bit 2 when enabled, unmasked
// - flags stay until written one; reset zero
// - status register mirrors live detector states
// - status bit 0 shows converter actually running
// - masks gate flags only; reset 0x7C
// - mask bits 6,4,3,2 match event bits
// - codes 0-7 release after converter enable
// - codes 8-F release after linear regulator enable
// - function field picks pin behaviour
// - range bit frozen while converter enabled
// - range bit selects low or high range
// - voltage codes above 0x1A clamp to 0x1A
// - discharge when disabled unless bit 5 set
// - discharge on fault-off unless bit 4 set
// - peak limit field passed to converter
// - event mode pulls pin low on flags except bit 7
// - reset mode holds pin low until release
// ----------------------------------------------------------------------
`timescale 1ns/1ps
module pesc_regs #(
   parameter int unsigned UNIT_CYCLES = pesc_pkg::UNIT_CYCLES
) (
   input  wire logic                    clk_i,
   input  wire logic                    sys_rst_i,
   input  wire pesc_pkg::pesc_reg_req_t reg_req_i,
   output logic [7:0]                   reg_rdata_o,
   input  wire pesc_pkg::pesc_fault_t   fault_pins_i,
   input  wire logic                    linear_reg_enable_i,
   output logic                         conv_enable_o,
   output logic                         conv_range_sel_o,
   output logic [4:0]                   conv_voltage_code_o,
   output logic [1:0]                   peak_limit_sel_o,
   output logic                         conv_discharge_ctrl_o,
   output logic                         general_output_pin_o,
   output logic                         general_output_pin_oe_o
);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [7:0]            evt_r;
   logic [7:0]            mask_r;
   logic [7:0]            pin_r;
   logic [7:0]            conv_r;
   logic [7:0]            cfg_r;
   logic [7:0]            evt_nxt;
   logic [7:0]            mask_nxt;
   logic [7:0]            pin_nxt;
   logic [7:0]            conv_nxt;
   logic [7:0]            cfg_nxt;
   logic [7:0]            rdata_nxt;
   logic [7:0]            stat_val;
   logic [7:0]            set_vec;
   logic [7:0]            clr_vec;
   logic [7:0]            conv_wmask;
   pesc_pkg::pesc_fault_t live;
   logic                  wr_evt;
   logic                  wr_mask;
   logic                  wr_pin;
   logic                  wr_conv;
   logic                  wr_cfg;
   logic                  conv_en;
   logic [3:0]            pin_fn;
   logic [3:0]            rel_code;
   logic                  rel_src;
   logic                  pulse_active;
   logic                  any_event;
   logic                  pin_oe_nxt;
   logic                  discharge_nxt;
   logic [4:0]            vcode_nxt;

   // ----------------------------------------------------------------
   // detector pins into the clock domain
   // ----------------------------------------------------------------
   pesc_pin_sync #(
      .WIDTH (pesc_pkg::SYNC_W)
   ) u_sync (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (fault_pins_i),
      .sync_o    (live)
   );

   // ----------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------
   assign wr_evt  = reg_req_i.wr && (reg_req_i.addr == pesc_pkg::EVT_OFS);
   assign wr_mask = reg_req_i.wr && (reg_req_i.addr == pesc_pkg::MASK_OFS);
   assign wr_pin  = reg_req_i.wr && (reg_req_i.addr == pesc_pkg::PIN_OFS);
   assign wr_conv = reg_req_i.wr && (reg_req_i.addr == pesc_pkg::CONV_OFS);
   assign wr_cfg  = reg_req_i.wr && (reg_req_i.addr == pesc_pkg::CFG_OFS);

   assign conv_en  = conv_r[pesc_pkg::BIT_EN];
   assign pin_fn   = pin_r[pesc_pkg::FN_LSB +: 4];
   assign rel_code = pin_r[pesc_pkg::REL_LSB +: 4];
   assign rel_src  = rel_code[pesc_pkg::REL_SRC_BIT];

   // ----------------------------------------------------------------
   // event flag set and clear
   // ----------------------------------------------------------------
   always_comb begin
      set_vec = 8'h00;
      set_vec[pesc_pkg::BIT_OT]  = live.overtemp;
      set_vec[pesc_pkg::BIT_SUV] = live.supply_lockout
                                   & ~mask_r[pesc_pkg::BIT_SUV];
      set_vec[pesc_pkg::BIT_OC]  = live.overcurrent & conv_en
                                   & ~mask_r[pesc_pkg::BIT_OC];
      set_vec[pesc_pkg::BIT_OV]  = live.overvolt & conv_en
                                   & ~mask_r[pesc_pkg::BIT_OV];
      set_vec[pesc_pkg::BIT_UV]  = live.undervolt & conv_en
                                   & ~mask_r[pesc_pkg::BIT_UV];
   end

   // write one clears, a new event in the same cycle wins
   assign clr_vec = wr_evt ? (reg_req_i.wdata & pesc_pkg::EVT_WMASK) : 8'h00;
   assign evt_nxt = ((evt_r & ~clr_vec) | set_vec) & pesc_pkg::EVT_WMASK;

   // ----------------------------------------------------------------
   // control register next values
   // ----------------------------------------------------------------
   assign mask_nxt = wr_mask ? (reg_req_i.wdata & pesc_pkg::MASK_WMASK) : mask_r;
   assign pin_nxt  = wr_pin ? reg_req_i.wdata : pin_r;
   assign cfg_nxt  = wr_cfg ? (reg_req_i.wdata & pesc_pkg::CFG_WMASK) : cfg_r;

   // range bit writable only while the converter is off
   assign conv_wmask = conv_en ? (pesc_pkg::CONV_WMASK & ~(8'h01 << pesc_pkg::BIT_RANGE))
                               : pesc_pkg::CONV_WMASK;
   assign conv_nxt   = wr_conv ? ((reg_req_i.wdata & conv_wmask) | (conv_r & ~conv_wmask))
                               : conv_r;

   // ----------------------------------------------------------------
   // status and read mux
   // ----------------------------------------------------------------
   always_comb begin
      stat_val = 8'h00;
      stat_val[pesc_pkg::BIT_OT]  = live.overtemp;
      stat_val[pesc_pkg::BIT_SUV] = live.supply_lockout;
      stat_val[pesc_pkg::BIT_OC]  = live.overcurrent;
      stat_val[pesc_pkg::BIT_OV]  = live.overvolt;
      stat_val[pesc_pkg::BIT_UV]  = live.undervolt;
      stat_val[pesc_pkg::BIT_RUN] = live.conv_running;
   end

   // unmapped offsets read as zero
   always_comb begin
      case (reg_req_i.addr)
         pesc_pkg::EVT_OFS:  rdata_nxt = evt_r;
         pesc_pkg::STAT_OFS: rdata_nxt = stat_val;
         pesc_pkg::MASK_OFS: rdata_nxt = mask_r;
         pesc_pkg::PIN_OFS:  rdata_nxt = pin_r;
         pesc_pkg::CONV_OFS: rdata_nxt = conv_r;
         pesc_pkg::CFG_OFS:  rdata_nxt = cfg_r;
         default:            rdata_nxt = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // reset pulse release timing
   // ----------------------------------------------------------------
   pesc_release_timer #(
      .UNIT_CYCLES (UNIT_CYCLES)
   ) u_timer (
      .clk_i          (clk_i),
      .sys_rst_i      (sys_rst_i),
      .src_en_i       (rel_src ? linear_reg_enable_i : conv_en),
      .units_i        (pesc_pkg::release_units(rel_code[2:0])),
      .pulse_active_o (pulse_active)
   );

   // ----------------------------------------------------------------
   // output pin function
   // ----------------------------------------------------------------
   assign any_event = evt_r[pesc_pkg::BIT_SUV] | evt_r[pesc_pkg::BIT_OC]
                    | evt_r[pesc_pkg::BIT_OV] | evt_r[pesc_pkg::BIT_UV];

   // enable high means the pin is pulled low
   always_comb begin
      case (pin_fn)
         pesc_pkg::FN_RST_PULSE: pin_oe_nxt = pulse_active;
         pesc_pkg::FN_PG_LOW:    pin_oe_nxt = ~live.supply_lockout;
         pesc_pkg::FN_PG_HIGH:   pin_oe_nxt = live.supply_lockout;
         pesc_pkg::FN_EVENT:     pin_oe_nxt = any_event;
         pesc_pkg::FN_FORCE_LOW: pin_oe_nxt = 1'b1;
         pesc_pkg::FN_FORCE_HIZ: pin_oe_nxt = 1'b0;
         default:                pin_oe_nxt = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // converter controls
   // ----------------------------------------------------------------
   assign discharge_nxt = (~conv_en & ~cfg_r[pesc_pkg::BIT_DIS_OFF])
                        | (conv_en & live.conv_fault_off
                           & ~cfg_r[pesc_pkg::BIT_DIS_FLT]);
   assign vcode_nxt = (conv_r[pesc_pkg::VCODE_LSB +: 5] > pesc_pkg::VCODE_MAX)
                    ? pesc_pkg::VCODE_MAX : conv_r[pesc_pkg::VCODE_LSB +: 5];

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         evt_r  <= pesc_pkg::EVT_RST;
         mask_r <= pesc_pkg::MASK_RST;
         pin_r  <= pesc_pkg::PIN_RST;
         conv_r <= pesc_pkg::CONV_RST;
         cfg_r  <= pesc_pkg::CFG_RST;
      end else begin
         evt_r  <= evt_nxt;
         mask_r <= mask_nxt;
         pin_r  <= pin_nxt;
         conv_r <= conv_nxt;
         cfg_r  <= cfg_nxt;
      end
   end

   // registered outputs
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         reg_rdata_o             <= 8'h00;
         conv_enable_o           <= 1'b0;
         conv_range_sel_o        <= pesc_pkg::CONV_RST[pesc_pkg::BIT_RANGE];
         conv_voltage_code_o     <= pesc_pkg::CONV_RST[pesc_pkg::VCODE_LSB +: 5];
         peak_limit_sel_o        <= 2'h0;
         conv_discharge_ctrl_o   <= 1'b1;
         general_output_pin_o    <= 1'b0;
         general_output_pin_oe_o <= 1'b0;
      end else begin
         reg_rdata_o             <= reg_req_i.rd ? rdata_nxt : reg_rdata_o;
         conv_enable_o           <= conv_en;
         conv_range_sel_o        <= conv_r[pesc_pkg::BIT_RANGE];
         conv_voltage_code_o     <= vcode_nxt;
         peak_limit_sel_o        <= cfg_r[pesc_pkg::LIM_LSB +: 2];
         conv_discharge_ctrl_o   <= discharge_nxt;
         general_output_pin_o    <= 1'b0;
         general_output_pin_oe_o <= pin_oe_nxt;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   a_ot_flag_set: assert property (
      live.overtemp |=> evt_r[pesc_pkg::BIT_OT])
      else $error("overtemperature did not set its flag");
   a_suv_flag_mask: assert property (
      $rose(evt_r[pesc_pkg::BIT_SUV]) |-> $past(live.supply_lockout
                                                & ~mask_r[pesc_pkg::BIT_SUV]))
      else $error("supply flag set without cause or while masked");
   a_oc_flag_gate: assert property (
      $rose(evt_r[pesc_pkg::BIT_OC]) |-> $past(live.overcurrent && conv_en
                                               && !mask_r[pesc_pkg::BIT_OC]))
      else $error("overcurrent flag set outside its gate");
   a_ov_flag_gate: assert property (
      live.overvolt && conv_en && !mask_r[pesc_pkg::BIT_OV]
      |=> evt_r[pesc_pkg::BIT_OV])
      else $error("overvoltage flag missed");
   a_uv_flag_gate: assert property (
      $rose(evt_r[pesc_pkg::BIT_UV]) |-> $past(live.undervolt && conv_en
                                               && !mask_r[pesc_pkg::BIT_UV]))
      else $error("undervoltage flag set outside its gate");
   a_flag_clear_w1c: assert property (
      $fell(evt_r[pesc_pkg::BIT_OT]) |-> $past(wr_evt && reg_req_i.wdata[pesc_pkg::BIT_OT]))
      else $error("flag cleared without a write of one");
   a_status_track: assert property (
      reg_req_i.rd && reg_req_i.addr == pesc_pkg::STAT_OFS
      |=> reg_rdata_o == $past(stat_val) && reg_rdata_o[5] == 1'b0)
      else $error("status read does not show live detectors");
   a_range_locked: assert property (
      conv_en && wr_conv |=> $stable(conv_r[pesc_pkg::BIT_RANGE]))
      else $error("range bit changed while enabled");
   a_vcode_clamped: assert property (
      conv_voltage_code_o <= pesc_pkg::VCODE_MAX)
      else $error("voltage code above top step");
   a_discharge_off: assert property (
      !conv_en && !cfg_r[pesc_pkg::BIT_DIS_OFF] ##1 !conv_en |-> conv_discharge_ctrl_o)
      else $error("discharge missing while disabled");
   a_event_pin_low: assert property (
      pin_fn == pesc_pkg::FN_EVENT && any_event ##1 pin_fn == pesc_pkg::FN_EVENT
      |-> general_output_pin_oe_o)
      else $error("event pin not pulled low");
   a_reset_pin_low: assert property (
      pin_fn == pesc_pkg::FN_RST_PULSE && pulse_active
      |=> general_output_pin_oe_o)
      else $error("reset pulse not driven low");

   c_flag_clear: cover property (wr_evt ##1 evt_r == 8'h00);
   c_pulse_end: cover property (pin_fn == pesc_pkg::FN_RST_PULSE && $fell(pulse_active));
   c_event_pin: cover property (pin_fn == pesc_pkg::FN_EVENT && any_event);

endmodule

// [common/pesc_pkg.sv]
// constants and carrier types for the event, status and converter control registers
package pesc_pkg;

   // -------------------------------------------------
   // register offsets
   // -------------------------------------------------
   localparam logic [7:0] EVT_OFS  = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h02;
   localparam logic [7:0] MASK_OFS = 8'h03;
   localparam logic [7:0] PIN_OFS  = 8'h04;
   localparam logic [7:0] CONV_OFS = 8'h05;
   localparam logic [7:0] CFG_OFS  = 8'h06;

   // -------------------------------------------------
   // values after reset and writable bits
   // -------------------------------------------------
   localparam logic [7:0] EVT_RST      = 8'h00;
   localparam logic [7:0] MASK_RST     = 8'h7C;
   localparam logic [7:0] PIN_RST      = 8'h00;
   localparam logic [7:0] CONV_RST     = 8'h58;
   localparam logic [7:0] CFG_RST      = 8'h00;
   localparam logic [7:0] EVT_WMASK    = 8'hDC;
   localparam logic [7:0] MASK_WMASK   = 8'h5C;
   localparam logic [7:0] CONV_WMASK   = 8'hDF;
   localparam logic [7:0] CFG_WMASK    = 8'h33;

   // -------------------------------------------------
   // field positions
   // -------------------------------------------------
   localparam int BIT_OT       = 7;
   localparam int BIT_SUV      = 6;
   localparam int BIT_OC       = 4;
   localparam int BIT_OV       = 3;
   localparam int BIT_UV       = 2;
   localparam int BIT_RUN      = 0;
   localparam int BIT_EN       = 7;
   localparam int BIT_RANGE    = 6;
   localparam int BIT_DIS_OFF  = 5;
   localparam int BIT_DIS_FLT  = 4;
   localparam int VCODE_LSB    = 0;
   localparam int LIM_LSB      = 0;
   localparam int FN_LSB       = 0;
   localparam int REL_LSB      = 4;
   localparam int REL_SRC_BIT  = 3;
   localparam logic [4:0] VCODE_MAX = 5'h1A;

   // -------------------------------------------------
   // output pin functions
   // -------------------------------------------------
   localparam logic [3:0] FN_RST_PULSE = 4'h1;
   localparam logic [3:0] FN_PG_LOW    = 4'h2;
   localparam logic [3:0] FN_PG_HIGH   = 4'h3;
   localparam logic [3:0] FN_EVENT     = 4'h4;
   localparam logic [3:0] FN_FORCE_LOW = 4'h8;
   localparam logic [3:0] FN_FORCE_HIZ = 4'h9;

   // -------------------------------------------------
   // release timing
   // -------------------------------------------------
   localparam int unsigned CLK_FREQ_HZ   = 50_000_000;
   localparam int unsigned PULSE_UNIT_MS = 8;
   localparam int unsigned UNIT_CYCLES   = PULSE_UNIT_MS * (CLK_FREQ_HZ / 1000);
   localparam int          PRESC_W       = 19;
   localparam int          SYNC_W        = 7;

   // -------------------------------------------------
   // carriers
   // -------------------------------------------------
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pesc_reg_req_t;

   typedef struct packed {
      logic overtemp;
      logic supply_lockout;
      logic overcurrent;
      logic overvolt;
      logic undervolt;
      logic conv_running;
      logic conv_fault_off;
   } pesc_fault_t;

   // number of 8 ms units for a release code: 1,2,4,6,...,14
   function automatic logic [3:0] release_units(input logic [2:0] code);
      release_units = (code == 3'h0) ? 4'h1 : {code, 1'b0};
   endfunction

endpackage

// [core/pesc_pin_sync.sv]
// three-stage synchroniser with agreement filter for detector pins
`timescale 1ns/1ps
module pesc_pin_sync #(
   parameter int WIDTH = pesc_pkg::SYNC_W
) (
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   logic [WIDTH-1:0] sync_nxt;

   // take each bit only where stages two and three agree
   assign sync_nxt = (s2_r & s3_r) | (sync_o & (s2_r | s3_r));

   // shift chain
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         s1_r   <= '0;
         s2_r   <= '0;
         s3_r   <= '0;
         sync_o <= '0;
      end else begin
         s1_r   <= async_i;
         s2_r   <= s1_r;
         s3_r   <= s2_r;
         sync_o <= sync_nxt;
      end
   end

endmodule

// [core/pesc_release_timer.sv]
// reset pulse release timer counting 8 ms units after an enable rises
`timescale 1ns/1ps
module pesc_release_timer #(
   parameter int unsigned UNIT_CYCLES = pesc_pkg::UNIT_CYCLES
) (
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       src_en_i,
   input  wire logic [3:0] units_i,
   output logic            pulse_active_o
);

   localparam logic [pesc_pkg::PRESC_W-1:0] PRESC_LAST =
      pesc_pkg::PRESC_W'(UNIT_CYCLES - 1);

   logic                        src_d_r;
   logic                        running_r;
   logic [pesc_pkg::PRESC_W-1:0] presc_r;
   logic [3:0]                  unit_r;
   logic                        tick;
   logic                        rise;
   logic                        last_unit;

   // one-cycle enable every unit, units counted up to the selected delay
   assign rise      = src_en_i & ~src_d_r;
   assign tick      = running_r & (presc_r == PRESC_LAST);
   assign last_unit = tick & ((unit_r + 4'h1) >= units_i);

   // pulse stays high until the delay has run with the enable held
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         src_d_r        <= 1'b0;
         running_r      <= 1'b0;
         presc_r        <= '0;
         unit_r         <= 4'h0;
         pulse_active_o <= 1'b1;
      end else begin
         src_d_r <= src_en_i;
         if (!src_en_i || rise) begin
            running_r      <= src_en_i;
            presc_r        <= '0;
            unit_r         <= 4'h0;
            pulse_active_o <= 1'b1;
         end else if (running_r) begin
            presc_r <= tick ? '0 : presc_r + 1'b1;
            if (tick) begin
               unit_r <= unit_r + 4'h1;
            end
            if (last_unit) begin
               running_r      <= 1'b0;
               pulse_active_o <= 1'b0;
            end
         end
      end
   end

endmodule

// [test/pesc_host_model.sv]
// host side model issuing single-byte register requests
`timescale 1ns/1ps
module pesc_host_model (
   input  wire logic              clk_i,
   input  wire logic [7:0]        rdata_i,
   output pesc_pkg::pesc_reg_req_t reg_req_o
);
   initial reg_req_o = '0;

   // one-cycle request; idle lines flip away from the last value
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                         output logic [7:0] q);
      @(posedge clk_i);
      #1;
      reg_req_o = {w, ~w, a, d};
      @(posedge clk_i);
      #1;
      q = rdata_i;
      reg_req_o = {2'b00, ~a, ~d};
   endtask
endmodule

// [test/testbench.sv]
// self-checking bench for the event, status and converter registers
`timescale 1ns/1ps
module testbench;
   logic                    clk_i = 1'b0;
   logic                    sys_rst_i = 1'b1;
   pesc_pkg::pesc_reg_req_t reg_req;
   pesc_pkg::pesc_fault_t   pins = '0;
   logic                    ldo_en = 1'b0;
   logic [7:0]              rdata;
   logic [7:0]              q;
   logic                    en, rng, dis, gp, oe;
   logic [4:0]              vcode;
   logic [1:0]              lim;
   int                      n_fail = 0;
   int                      samples_checked = 0;
   logic [7:0]              ra [7] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07};
   logic [7:0]              re [7] = '{8'h00, 8'h00, 8'h7C, 8'h00, 8'h58, 8'h00, 8'h00};
   logic [7:0]              fn [5] = '{8'h08, 8'h09, 8'h02, 8'h03, 8'h02};
   logic [4:0]              lk = 5'h0C;
   logic [4:0]              ex = 5'h19;
   logic [7:0]              rc [3] = '{8'h01, 8'h31, 8'h81};
   int                      un [3] = '{1, 6, 1};

   always #10 clk_i = ~clk_i;

   pesc_host_model i_pesc_host_model (.clk_i(clk_i), .rdata_i(rdata), .reg_req_o(reg_req));

   pesc_regs #(.UNIT_CYCLES(10)) i_pesc_regs (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_req_i(reg_req), .reg_rdata_o(rdata),
      .fault_pins_i(pins), .linear_reg_enable_i(ldo_en), .conv_enable_o(en),
      .conv_range_sel_o(rng), .conv_voltage_code_o(vcode), .peak_limit_sel_o(lim),
      .conv_discharge_ctrl_o(dis), .general_output_pin_o(gp), .general_output_pin_oe_o(oe));

   // compare helpers, bytes and single bits
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chkb(input string nm, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_pesc_host_model.access(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      i_pesc_host_model.access(1'b0, a, 8'h00, q);
      chk($sformatf("reg %h", a), e, q);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic end_of_test();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // watchdog, far beyond the roughly 300 cycles of the run
   initial begin
      #200_000;
      n_fail++;
      end_of_test();
   end

   // -------------------------------------------------
   // test sequence
   // -------------------------------------------------
   initial begin
      cyc(8);
      sys_rst_i = 1'b0;
      for (int i = 0; i < 7; i++) rd(ra[i], re[i]);
      chkb("range", 1'b1, rng);
      chk("vcode", 8'h18, {3'h0, vcode});
      chkb("discharge", 1'b1, dis);
      chkb("pin data", 1'b0, gp);
      chkb("enable", 1'b0, en);
      chkb("pin oe", 1'b0, oe);
      wr(8'h03, 8'hFF);
      rd(8'h03, 8'h5C);
      wr(8'h02, 8'hFF);
      rd(8'h02, 8'h00);
      wr(8'h07, 8'hFF);
      rd(8'h07, 8'h00);
      wr(8'h06, 8'h02);
      cyc(2);
      chk("limit", 8'h02, {6'h00, lim});
      wr(8'h05, 8'h1F);
      rd(8'h05, 8'h1F);
      chkb("range", 1'b0, rng);
      chk("vcode", 8'h1A, {3'h0, vcode});
      wr(8'h05, 8'hC5);
      wr(8'h05, 8'h85);
      rd(8'h05, 8'hC5);
      chkb("range", 1'b1, rng);
      chkb("enable", 1'b1, en);
      // faults with masks set, then cleared
      pins = 7'h7E;
      cyc(8);
      rd(8'h02, 8'hDD);
      rd(8'h00, 8'h80);
      wr(8'h03, 8'h00);
      rd(8'h00, 8'hDC);
      wr(8'h04, 8'h04);
      cyc(2);
      chkb("pin oe", 1'b1, oe);
      pins = 7'h00;
      cyc(8);
      wr(8'h00, 8'h00);
      rd(8'h00, 8'hDC);
      wr(8'h00, 8'h48);
      rd(8'h00, 8'h94);
      chkb("pin oe", 1'b1, oe);
      wr(8'h00, 8'h94);
      rd(8'h00, 8'h00);
      cyc(2);
      chkb("pin oe", 1'b0, oe);
      // converter off: no converter events, status still live
      wr(8'h05, 8'h05);
      pins = 7'h1C;
      cyc(8);
      rd(8'h00, 8'h00);
      rd(8'h02, 8'h1C);
      chkb("enable", 1'b0, en);
      pins = 7'h00;
      chkb("discharge", 1'b1, dis);
      wr(8'h06, 8'h20);
      cyc(2);
      chkb("discharge", 1'b0, dis);
      wr(8'h05, 8'h85);
      pins = 7'h03;
      cyc(8);
      chkb("discharge", 1'b1, dis);
      wr(8'h06, 8'h30);
      cyc(2);
      chkb("discharge", 1'b0, dis);
      // pin functions
      for (int i = 0; i < 5; i++) begin
         pins = lk[i] ? 7'h20 : 7'h00;
         cyc(8);
         wr(8'h04, fn[i]);
         cyc(2);
         chkb("pin oe", ex[i], oe);
      end
      // reset pulse release timing from either enable
      for (int i = 0; i < 3; i++) begin
         wr(8'h04, rc[i]);
         if (i == 2) begin
            ldo_en = 1'b0;
            cyc(3);
         end else begin
            wr(8'h05, 8'h05);
            cyc(2);
         end
         chkb("pin oe", 1'b1, oe);
         if (i == 2) ldo_en = 1'b1;
         else wr(8'h05, 8'h85);
         cyc(un[i] * 10 - 3);
         chkb("pin oe", 1'b1, oe);
         cyc(8);
         chkb("pin oe", 1'b0, oe);
      end
      end_of_test();
   end
endmodule
